// ### hw/timer_ch0_io_control.v
// channel 0 io control: four general registers as compare or capture
// assumes an axi4-lite master, a 16-bit channel 0 counter and the
// channel 1 count strobes supplied by neighbouring timer blocks
//
// What this block does
// - b buffer bit pairs register d with b
// - c and d fields share one reset-zero register
// - codes x000,x100 disable output; bit 2 initial level
// - action 01 drives pin low on match
// - action 10 drives pin high on match
// - action 11 toggles pin on match
// - code 1000 captures on rising pin edge
// - code 1001 captures on falling pin edge
// - codes 101x capture on both pin edges
// - codes 11xx capture on channel 1 count
// - undivided channel 1 clock gives no capture
// - a buffer bit silences register c
// - b buffer bit silences register d
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_io_defs.vh"

module timer_ch0_io_control (
   input wire CLOCK_I,
   input wire RST_B_I,
   input wire [31:0] S_AXI_AWADDR_I,
   input wire S_AXI_AWVALID_I,
   output wire S_AXI_AWREADY_O,
   input wire [31:0] S_AXI_WDATA_I,
   input wire [3:0] S_AXI_WSTRB_I,
   input wire S_AXI_WVALID_I,
   output wire S_AXI_WREADY_O,
   output reg [1:0] S_AXI_BRESP_O,
   output reg S_AXI_BVALID_O,
   input wire S_AXI_BREADY_I,
   input wire [31:0] S_AXI_ARADDR_I,
   input wire S_AXI_ARVALID_I,
   output wire S_AXI_ARREADY_O,
   output reg [31:0] S_AXI_RDATA_O,
   output reg [1:0] S_AXI_RRESP_O,
   output reg S_AXI_RVALID_O,
   input wire S_AXI_RREADY_I,
   input wire [15:0] COUNTER_I,
   input wire CH1_COUNT_I,
   input wire [3:0] PIN_IN_I,
   output wire [3:0] PIN_OUT_O,
   output wire [3:0] PIN_OE_B_O,
   output wire [3:0] CAPTURE_O,
   output wire [3:0] MATCH_O,
   output wire IRQ_O
);

   // ****************************************
   // register state
   // ****************************************
   reg [7:0] io_ab_q;
   reg [7:0] io_cd_q;
   reg [7:0] mode_q;
   reg [7:0] ch1_ctl_q;
   reg [15:0] gr_q [0:3];
   reg [7:0] status_q;
   reg [7:0] mask_q;
   reg [3:0] pin_q;
   reg [3:0] oe_q;
   reg [3:0] pin_prev_q;
   reg [3:0] cap_q;
   reg [3:0] mat_q;

   // ****************************************
   // axi4-lite write path
   // ****************************************
   reg aw_got_q;
   reg w_got_q;
   reg [5:0] aw_addr_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;
   wire wr_fire;
   wire [5:0] wa;
   wire wr_hit;
   wire [3:0] gr_wr;

   // address and data latched independently, response after both
   assign S_AXI_AWREADY_O = !aw_got_q && !S_AXI_BVALID_O;
   assign S_AXI_WREADY_O = !w_got_q && !S_AXI_BVALID_O;
   assign wr_fire = aw_got_q && w_got_q && !S_AXI_BVALID_O;
   assign wa = aw_addr_q;
   // counter readback is read only, so a write to it is refused
   assign wr_hit = (wa == `OFF_IO_AB) ||
      (wa == `OFF_IO_CD) ||
      (wa == `OFF_MODE) ||
      (wa[5:4] == `OFF_GR_BASE) ||
      (wa == `OFF_STATUS) ||
      (wa == `OFF_MASK) ||
      (wa == `OFF_CH1_CTL);

   always @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         aw_addr_q <= 6'h00;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
         S_AXI_BVALID_O <= 1'b0;
         S_AXI_BRESP_O <= `AXI_OKAY;
      end else begin
         if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
            aw_got_q <= 1'b1;
            aw_addr_q <= S_AXI_AWADDR_I[5:0];
         end
         if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
            w_got_q <= 1'b1;
            w_data_q <= S_AXI_WDATA_I;
            w_strb_q <= S_AXI_WSTRB_I;
         end
         if (wr_fire) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            S_AXI_BVALID_O <= 1'b1;
            S_AXI_BRESP_O <= wr_hit ? `AXI_OKAY : `AXI_SLVERR;
         end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
            S_AXI_BVALID_O <= 1'b0;
         end
      end
   end

   // ****************************************
   // address map, one word per register
   // ****************************************
   // 0x00 io control a and b, a field low nibble
   // 0x04 io control c and d, c field low nibble
   // 0x08 mode: buffer pairing bits, top two bits read one
   // 0x0C channel 0 counter, read only
   // 0x10 general register a
   // 0x14 general register b
   // 0x18 general register c
   // 0x1C general register d
   // 0x20 status, cleared by reading it
   // 0x24 interrupt mask
   // 0x28 channel 1 control, prescaler select in bits 2:0
   // every other word answers with slverr
   // address bits 5:0 are decoded, higher bits are ignored
   // so the map repeats every 64 bytes

   // ****************************************
   // axi4-lite read path
   // ****************************************
   wire rd_fire;
   reg [31:0] rd_mux;
   reg rd_hit;
   wire [5:0] ra;
   wire rd_status;

   assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;
   assign rd_fire = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
   assign ra = S_AXI_ARADDR_I[5:0];
   assign rd_status = rd_fire && (ra == `OFF_STATUS);

   // read data selection, unmapped reads zero with slverr
   always @* begin
      rd_mux = 32'h00000000;
      rd_hit = 1'b1;
      if (ra == `OFF_IO_AB)
         rd_mux[7:0] = io_ab_q;
      else if (ra == `OFF_IO_CD)
         rd_mux[7:0] = io_cd_q;
      else if (ra == `OFF_MODE)
         rd_mux[7:0] = mode_q;
      else if (ra == `OFF_CNT0)
         rd_mux[15:0] = COUNTER_I;
      else if (ra[5:4] == `OFF_GR_BASE)
         rd_mux[15:0] = gr_q[ra[3:2]];
      else if (ra == `OFF_STATUS)
         rd_mux[7:0] = status_q;
      else if (ra == `OFF_MASK)
         rd_mux[7:0] = mask_q;
      else if (ra == `OFF_CH1_CTL)
         rd_mux[7:0] = ch1_ctl_q;
      else
         rd_hit = 1'b0;
   end

   always @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         S_AXI_RVALID_O <= 1'b0;
         S_AXI_RDATA_O <= 32'h00000000;
         S_AXI_RRESP_O <= `AXI_OKAY;
      end else if (rd_fire) begin
         S_AXI_RVALID_O <= 1'b1;
         S_AXI_RDATA_O <= rd_mux;
         S_AXI_RRESP_O <= rd_hit ? `AXI_OKAY : `AXI_SLVERR;
      end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
         S_AXI_RVALID_O <= 1'b0;
      end
   end

   // ****************************************
   // control registers
   // ****************************************
   wire ab_wr;
   wire cd_wr;
   assign ab_wr = wr_fire && wa == `OFF_IO_AB && w_strb_q[0];
   assign cd_wr = wr_fire && wa == `OFF_IO_CD && w_strb_q[0];

   // d field high nibble, c field low nibble
   always @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         io_ab_q <= `IO_RESET;
         io_cd_q <= `IO_RESET;
         mode_q <= `MODE_RESET;
         ch1_ctl_q <= 8'h00;
         mask_q <= 8'h00;
      end else if (wr_fire && w_strb_q[0]) begin
         if (ab_wr)
            io_ab_q <= w_data_q[7:0];
         if (cd_wr)
            io_cd_q <= w_data_q[7:0];
         if (wa == `OFF_MODE)
            mode_q <= {2'b11, w_data_q[5:0]};
         if (wa == `OFF_CH1_CTL)
            ch1_ctl_q <= w_data_q[7:0];
         if (wa == `OFF_MASK)
            mask_q <= w_data_q[7:0];
      end
   end

   // ****************************************
   // per-register compare and capture
   // ****************************************
   wire buf_a;
   wire buf_b;
   wire ch1_ok;
   wire [15:0] fields;
   assign buf_a = mode_q[`MODE_BUF_A];
   assign buf_b = mode_q[`MODE_BUF_B];
   assign ch1_ok = ch1_ctl_q[`PSC_LSB+2:`PSC_LSB] != `PSC_UNDIVIDED;
   // field layout: a in ab[3:0], b in ab[7:4], c in cd[3:0], d in cd[7:4]
   assign fields = {io_cd_q, io_ab_q};

   // timing of one register slice:
   // a pin edge is seen against the level held at the previous edge,
   // and the counter is loaded at the edge that sees it
   // a match is the counter equal to the stored value in this cycle,
   // and the pin action lands at the closing edge of that cycle
   // capture and match pulses leave one cycle later from flip-flops
   // a match is only counted while the slice is in compare use
   // a silenced slice keeps its stored value for the buffer logic
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_reg
         wire [3:0] fld;
         wire silent;
         wire oc_mode;
         wire oc_en;
         wire match;
         wire rise;
         wire fall;
         wire cap;
         wire gr_sw;
         wire fld_wr;
         assign fld = fields[gi*4+3:gi*4];
         // buffering c or d leaves it a plain store
         assign silent = (gi == 2 && buf_a) ||
            (gi == 3 && buf_b);
         assign oc_mode = !fld[3] && !silent;
         assign oc_en = oc_mode && fld[1:0] != 2'b00;
         assign match = oc_mode && COUNTER_I == gr_q[gi];
         assign rise = PIN_IN_I[gi] && !pin_prev_q[gi];
         assign fall = !PIN_IN_I[gi] && pin_prev_q[gi];
         assign cap = fld[3] && !silent && (
            (fld[2:0] == 3'b000 && rise) ||
            (fld[2:0] == 3'b001 && fall) ||
            (fld[2:1] == 2'b01 && (rise || fall)) ||
            (fld[2] && CH1_COUNT_I && ch1_ok));
         assign gr_sw = wr_fire && wa[5:4] == `OFF_GR_BASE &&
            wa[3:2] == gi;
         assign fld_wr = (gi < 2) ? ab_wr : cd_wr;

         // capture beats a software write in the same cycle
         always @(posedge CLOCK_I or negedge RST_B_I) begin
            if (!RST_B_I) begin
               gr_q[gi] <= 16'hFFFF;
            end else if (cap) begin
               gr_q[gi] <= COUNTER_I;
            end else if (gr_sw) begin
               gr_q[gi] <= w_data_q[15:0];
            end
         end

         // pin level: initial on field write, action on match
         always @(posedge CLOCK_I or negedge RST_B_I) begin
            if (!RST_B_I) begin
               pin_q[gi] <= 1'b0;
               oe_q[gi] <= 1'b0;
               pin_prev_q[gi] <= 1'b0;
               cap_q[gi] <= 1'b0;
               mat_q[gi] <= 1'b0;
            end else begin
               pin_prev_q[gi] <= PIN_IN_I[gi];
               oe_q[gi] <= oc_en;
               cap_q[gi] <= cap;
               mat_q[gi] <= match;
               if (fld_wr)
                  pin_q[gi] <= w_data_q[(gi%2)*4+2];
               else if (match && fld[1:0] == 2'b01)
                  pin_q[gi] <= 1'b0;
               else if (match && fld[1:0] == 2'b10)
                  pin_q[gi] <= 1'b1;
               else if (match && fld[1:0] == 2'b11)
                  pin_q[gi] <= !pin_q[gi];
            end
         end
      end
   endgenerate

   // ****************************************
   // interrupt status: captures bits 3:0, matches bits 7:4
   // ****************************************
   wire [7:0] events;
   assign events = {mat_q, cap_q};

   // event set wins over clear-on-read
   always @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I)
         status_q <= 8'h00;
      else if (rd_status)
         status_q <= events;
      else
         status_q <= status_q | events;
   end

   assign PIN_OUT_O = pin_q;
   assign PIN_OE_B_O = ~oe_q;
   assign CAPTURE_O = cap_q;
   assign MATCH_O = mat_q;
   assign IRQ_O = |(status_q & mask_q);

endmodule // timer_ch0_io_control
`default_nettype wire

// ### include/tmr_io_defs.vh
// register offsets, field positions, reset values for the channel 0 io control
// assumes inclusion by the timer io control design file only
`ifndef TMR_IO_DEFS_VH
`define TMR_IO_DEFS_VH

// ****************************************
// byte addresses on the axi4-lite slave
// ****************************************
`define OFF_IO_AB      6'h00
`define OFF_IO_CD      6'h04
`define OFF_MODE       6'h08
`define OFF_CNT0       6'h0C
// general registers a..d at 0x10..0x1C, address bits 5:4 equal 01
`define OFF_GR_BASE    2'h1
`define OFF_STATUS     6'h20
`define OFF_MASK       6'h24
`define OFF_CH1_CTL    6'h28

// ****************************************
// field positions and reset values
// ****************************************
`define IO_RESET       8'h00
`define MODE_RESET     8'hC0
`define MODE_BUF_A     4
`define MODE_BUF_B     5
`define PSC_LSB        0
`define PSC_UNDIVIDED  3'h0
`define AXI_OKAY       2'h0
`define AXI_SLVERR     2'h2

`endif

// ### verification/pin_partner.sv
// pin partner: outside drivers on the four capture/compare pins
// assumes the bench changes the driven levels just after a clock edge
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
   input wire logic [3:0] level_i,
   input wire logic [3:0] out_i,
   input wire logic [3:0] oe_b_i,
   output logic [3:0] pin_o
);
   // wire level: the block wins where it drives, else the outside level
   assign pin_o = (~oe_b_i & out_i) | (oe_b_i & level_i);
endmodule // pin_partner
`default_nettype wire

// ### verification/timer_ch0_io_control_bench.sv
// bench for the channel 0 io control block
// assumes the pin partner model and the bound port checker
`timescale 1ns/1ps
`default_nettype none
module timer_ch0_io_control_bench;
   // *****
   // wiring, bus tasks and tests
   // *****
   logic clk, rst_b = 1'h0, awv = 1'h0, wv = 1'h0, bready = 1'h0;
   logic arv = 1'h0, rready = 1'h0, ch1 = 1'h0, awr, wrdy, bv, arr, rv, irq;
   logic [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0, rdata, e;
   logic [15:0] cnt = 16'h0;
   logic [3:0] ext = 4'h0, pin, pout, oe_b, c;
   integer mismatches = 0, checks = 0;
   timer_ch0_io_control uut (
      .CLOCK_I(clk), .RST_B_I(rst_b), .S_AXI_AWADDR_I(awa),
      .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd),
      .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrdy),
      .S_AXI_BRESP_O(), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bready),
      .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
      .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(), .S_AXI_RVALID_O(rv),
      .S_AXI_RREADY_I(rready), .COUNTER_I(cnt), .CH1_COUNT_I(ch1),
      .PIN_IN_I(pin), .PIN_OUT_O(pout), .PIN_OE_B_O(oe_b),
      .CAPTURE_O(), .MATCH_O(), .IRQ_O(irq));
   pin_partner partner (.level_i(ext), .out_i(pout), .oe_b_i(oe_b),
      .pin_o(pin));
   // 100 ns clock
   initial begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end
   task tick(input integer k);
      repeat (k) @(posedge clk);
   endtask
   task compare(input [31:0] got, input [31:0] exp);
      begin
         checks++;
         if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // write: both halves offered, each dropped when taken
   task wr(input [7:0] a, input [31:0] d);
      integer n;
      begin
         @(posedge clk);
         n = 0;
         awa <= {24'h0, a};
         wd <= d;
         awv <= 1'h1;
         wv <= 1'h1;
         bready <= 1'h1;
         do begin
            @(posedge clk);
            n++;
            if (awr) awv <= 1'h0;
            if (wrdy) wv <= 1'h0;
         end while (bv !== 1'h1 && n < 40);
         bready <= 1'h0;
         if (n >= 40) mismatches++;
         tick(1);
      end
   endtask
   // read and compare against an expected word
   task rd(input [7:0] a, input [31:0] x);
      integer n;
      begin
         @(posedge clk);
         n = 0;
         ara <= {24'h0, a};
         arv <= 1'h1;
         rready <= 1'h1;
         do begin
            @(posedge clk);
            n++;
            if (arr) arv <= 1'h0;
         end while (rv !== 1'h1 && n < 40);
         rready <= 1'h0;
         if (n >= 40) mismatches++;
         compare(rdata, x);
      end
   endtask
   // counter equals v for one cycle, or one channel 1 count with the counter held at v
   task hit(input logic p, input [15:0] v);
      begin
         cnt <= v;
         ch1 <= p;
         tick(1);
         cnt <= p ? v : 16'h0;
         ch1 <= 1'h0;
         tick(2);
      end
   endtask
   task conclude;
      begin
         $display("checks %0d mismatches %0d", checks, mismatches);
         if (mismatches == 0 && checks > 0) $display("DONE - PASS");
         else $display("DONE - FAIL");
         $finish;
      end
   endtask
   // hang guard
   initial begin
      #2000000;
      mismatches++;
      conclude;
   end
   // test sequence
   initial begin
      tick(12);
      rst_b <= 1'h1;
      rd(8'h00, 32'h0);
      rd(8'h08, 32'hC0);
      compare(oe_b, 4'hF);
      wr(8'h04, 32'hFFFFFF5A);
      rd(8'h04, 32'h5A);
      wr(8'h10, 32'h5);
      for (c = 0; c < 8; c++) begin
         wr(8'h00, {28'h0, c});
         compare(oe_b[0], c[1:0] == 2'h0);
         if (c[1:0] != 2'h0) compare(pout[0], c[2]);
         hit(1'h0, 16'h5);
         e = c[1:0] == 2'h1 ? 0 : c[1:0] == 2'h2 ? 1 : !c[2];
         if (c[1:0] != 2'h0) compare(pout[0], e);
      end
      compare(irq, 1'h0);
      wr(8'h24, 32'h10);
      compare(irq, 1'h1);
      for (c = 8; c < 12; c++) begin
         wr(8'h00, {28'h0, c});
         wr(8'h10, 32'hFFFF);
         e = c == 9 ? 32'hFFFF : 32'h100 + c;
         cnt <= 16'h100 + c;
         ext <= 4'h1;
         tick(3);
         rd(8'h10, e);
         e = c == 8 ? e : 32'h200 + c;
         cnt <= 16'h200 + c;
         ext <= 4'h0;
         tick(3);
         rd(8'h10, e);
      end
      rd(8'h20, 32'h11);
      rd(8'h20, 32'h0);
      compare(irq, 1'h0);
      wr(8'h00, 32'hC);
      wr(8'h28, 32'h1);
      hit(1'h1, 16'hABC);
      rd(8'h10, 32'hABC);
      wr(8'h28, 32'h0);
      hit(1'h1, 16'hDEF);
      rd(8'h10, 32'hABC);
      wr(8'h08, 32'h30);
      rd(8'h08, 32'hF0);
      wr(8'h04, 32'h22);
      wr(8'h18, 32'h5);
      wr(8'h1C, 32'h5);
      hit(1'h0, 16'h5);
      compare(pout[3:2], 2'h0);
      wr(8'h08, 32'h0);
      hit(1'h0, 16'h5);
      compare(pout[3:2], 2'h3);
      conclude;
   end
endmodule // timer_ch0_io_control_bench
bind timer_ch0_io_control timer_io_chk chk (.*);
`default_nettype wire

// ### verification/timer_io_chk.sv
// port assertions for the channel 0 io control block
// assumes a bind onto the design top, names matched to its ports
`timescale 1ns/1ps
`default_nettype none
module timer_io_chk (
   input wire logic CLOCK_I,
   input wire logic RST_B_I,
   input wire logic S_AXI_AWVALID_I,
   input wire logic S_AXI_AWREADY_O,
   input wire logic S_AXI_WVALID_I,
   input wire logic S_AXI_WREADY_O,
   input wire logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   input wire logic S_AXI_ARVALID_I,
   input wire logic S_AXI_ARREADY_O,
   input wire logic S_AXI_RVALID_O,
   input wire logic CH1_COUNT_I,
   input wire logic [3:0] PIN_IN_I,
   input wire logic [3:0] PIN_OUT_O,
   input wire logic [3:0] CAPTURE_O,
   input wire logic [3:0] MATCH_O,
   input wire logic IRQ_O
);
   // *****
   // properties
   // *****
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (!RST_B_I);
   // both write halves taken at one edge
   sequence wr_taken;
      S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
   endsequence
   chk_wr_answer: assert property (wr_taken |-> ##2 S_AXI_BVALID_O)
      else $error("no write response");
   chk_rd_answer: assert property (
      S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
      else $error("no read response");
   chk_resp_hold: assert property (
      S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O)
      else $error("write response dropped");
   chk_aw_refused: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O)
      else $error("address taken during response");
   chk_ar_refused: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
      else $error("read taken during response");
   chk_pin_cause: assert property (
      $changed(PIN_OUT_O) |-> (|MATCH_O) || $rose(S_AXI_BVALID_O))
      else $error("pin moved without cause");
   chk_capture_cause: assert property (
      |CAPTURE_O |-> $past(PIN_IN_I) != $past(PIN_IN_I, 2) || $past(CH1_COUNT_I))
      else $error("capture without edge");
   chk_irq_cause: assert property (
      $rose(IRQ_O) |-> $rose(S_AXI_BVALID_O) || $past(|CAPTURE_O) ||
      $past(|MATCH_O))
      else $error("interrupt without event");
endmodule // timer_io_chk
`default_nettype wire
